// File: clsib_bank.sv
/*
  Climate sensor input register bank: selects active ranges and setpoints,
  drives the analogue levels and relays, and answers input-register reads.
  Measurements, trimmers and holding values come from logic on the
  same clock; the sensor link flag and jumpers from pins pass a synchroniser.
*/
`timescale 1ns/10ps
`include "clsib_map.svh"

// Overview of operation
// RULE_01: Report temperature, humidity, dew point in tenths.
// RULE_02: Report both analogue output levels, 0 to 1000. In overwrite the code passes the master's values unclipped.
// RULE_03: Temperature relay state at address 13.
// RULE_04: Humidity relay state at address 14.
// RULE_05: Report active temperature range code 1-5.
// RULE_06: Report active humidity range code 1-5.
// RULE_07: Report active temperature setpoint, 0 to 500.
// RULE_08: Report active humidity setpoint, 0 to 1000.
// RULE_09: Temperature hysteresis reads fixed value 20.
// RULE_10: Humidity hysteresis reads fixed value 50.
// RULE_11: Flag temperature setpoint outside working range.
// RULE_12: Flag humidity setpoint outside working range.
// RULE_13: Flag lost sensor module communication.
// RULE_14: Mode 1 uses holding values, else jumpers.
// RULE_15: Overwrite outputs only when mode and overwrite set.
// RULE_16: Reserved addresses read zero.
// RULE_17: Read returns current 16-bit register value.
// RULE_18: Relay on at setpoint, off past hysteresis.
module clsib_bank #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Measurements from the sensor front end
  input wire clsib_pkg::clsib_meas_t meas_i,
  input wire logic sensor_link_lost_i,
  // Standalone selections from jumpers and trimmers
  input wire logic [2:0] jumper_temp_range_i,
  input wire logic [2:0] jumper_hum_range_i,
  input wire logic [15:0] trimmer_temp_setpoint_i,
  input wire logic [15:0] trimmer_hum_setpoint_i,
  // Holding register values
  input wire logic operating_mode_i,
  input wire logic output_overwrite_i,
  input wire clsib_pkg::clsib_sel_t hold_temp_i,
  input wire clsib_pkg::clsib_sel_t hold_hum_i,
  input wire logic [15:0] overwrite_temp_level_i,
  input wire logic [15:0] overwrite_hum_level_i,
  // Input register read port
  input wire logic rd_req_i,
  input wire logic [7:0] rd_addr_i,
  output logic rd_valid_o,
  output logic [15:0] rd_data_o,
  // Outputs to the analogue stages and relay drivers
  output logic [15:0] temperature_analogue_out_o,
  output logic [15:0] humidity_analogue_out_o,
  output logic first_relay_normally_open_o,
  output logic second_relay_normally_open_o
);

  logic link_meta_r;
  logic link_sync_r;
  logic [2:0] jt_meta_r;
  logic [2:0] jt_sync_r;
  logic [2:0] jh_meta_r;
  logic [2:0] jh_sync_r;
  logic [2:0] temp_range_r;
  logic [2:0] hum_range_r;
  logic [15:0] temp_setp_r;
  logic [15:0] hum_setp_r;
  clsib_pkg::clsib_span_t temp_span_r;
  clsib_pkg::clsib_span_t hum_span_r;
  logic [15:0] temp_level_r;
  logic [15:0] hum_level_r;
  clsib_pkg::clsib_meas_t meas_r;
  logic temp_relay;
  logic hum_relay;
  logic temp_oor;
  logic hum_oor;
  logic [7:0] look_addr;
  logic [15:0] look_data;

  // Fixed table of the four preset spans plus the custom one
  function automatic clsib_pkg::clsib_span_t temp_span(input logic [2:0] code,
                                                       input clsib_pkg::clsib_span_t custom);
    clsib_pkg::clsib_span_t s;
    s.lo = `CLSIB_V_0;
    s.hi = `CLSIB_V_300;
    case (code)
      `CLSIB_RANGE_2: begin
        s.lo = `CLSIB_V_100;
        s.hi = `CLSIB_V_400;
      end
      `CLSIB_RANGE_3: begin
        s.lo = `CLSIB_V_200;
        s.hi = `CLSIB_V_500;
      end
      `CLSIB_RANGE_4: s.hi = `CLSIB_V_500;
      `CLSIB_RANGE_CUSTOM: s = custom;
      default: s.hi = `CLSIB_V_300;
    endcase
    return s;
  endfunction

  function automatic clsib_pkg::clsib_span_t hum_span(input logic [2:0] code,
                                                      input clsib_pkg::clsib_span_t custom);
    clsib_pkg::clsib_span_t s;
    s.lo = `CLSIB_V_200;
    s.hi = `CLSIB_V_900;
    case (code)
      `CLSIB_RANGE_2: begin
        s.lo = `CLSIB_V_0;
        s.hi = `CLSIB_V_600;
      end
      `CLSIB_RANGE_3: begin
        s.lo = `CLSIB_V_0;
        s.hi = `CLSIB_V_800;
      end
      `CLSIB_RANGE_4: begin
        s.lo = `CLSIB_V_0;
        s.hi = `CLSIB_V_1000;
      end
      `CLSIB_RANGE_CUSTOM: s = custom;
      default: s.hi = `CLSIB_V_900;
    endcase
    return s;
  endfunction

  // Codes outside 1..5 fall back to the first range
  function automatic logic [2:0] legal_code(input logic [2:0] code);
    if (code >= `CLSIB_RANGE_1 && code <= `CLSIB_RANGE_CUSTOM) begin
      return code;
    end
    return `CLSIB_RANGE_1;
  endfunction

  // Jumpers have no custom position, so 5 falls back to the first range too
  function automatic logic [2:0] jumper_code(input logic [2:0] code);
    if (code == `CLSIB_RANGE_CUSTOM) begin
      return `CLSIB_RANGE_1;
    end
    return legal_code(code);
  endfunction

  // Level of a measurement across the active span, 0 to 1000
  function automatic logic [15:0] scale(input logic signed [15:0] v,
                                        input clsib_pkg::clsib_span_t s);
    logic signed [17:0] num;
    logic [15:0] den;
    logic [31:0] q;
    num = 18'(v) - 18'($signed({1'b0, s.lo}));
    den = s.hi - s.lo;
    q = 32'h0;
    // Below the span clips to 0; a custom span with hi <= lo reads 0 as well
    if (num <= 18'sd0 || s.hi <= s.lo) begin
      return 16'h0000;
    end
    q = (32'(num) * 32'(`CLSIB_OUT_FULL)) / 32'(den);
    if (q > 32'(`CLSIB_OUT_FULL)) begin
      return `CLSIB_OUT_FULL;
    end
    return q[15:0];
  endfunction

  // Pin-level inputs: two flops before use; only the second flop is read
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      link_meta_r <= 1'b0;
      link_sync_r <= 1'b0;
    end else begin
      link_meta_r <= sensor_link_lost_i;
      link_sync_r <= link_meta_r; // RULE_13
    end
  end

  // Bits of a moving jumper may land a cycle apart, so one odd code can pass briefly
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      jt_meta_r <= `CLSIB_RANGE_1;
      jt_sync_r <= `CLSIB_RANGE_1;
    end else begin
      jt_meta_r <= jumper_temp_range_i;
      jt_sync_r <= jt_meta_r;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      jh_meta_r <= `CLSIB_RANGE_1;
      jh_sync_r <= `CLSIB_RANGE_1;
    end else begin
      jh_meta_r <= jumper_hum_range_i;
      jh_sync_r <= jh_meta_r;
    end
  end

  // One registered copy feeds relays, levels and reads alike
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meas_r <= '0;
    end else begin
      meas_r <= meas_i; // RULE_01
    end
  end

  // Source of ranges
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      temp_range_r <= `CLSIB_RANGE_1;
      hum_range_r <= `CLSIB_RANGE_1;
    end else if (operating_mode_i) begin
      temp_range_r <= legal_code(hold_temp_i.range_code); // RULE_14
      hum_range_r <= legal_code(hold_hum_i.range_code); // RULE_14
    end else begin
      temp_range_r <= jumper_code(jt_sync_r); // RULE_14
      hum_range_r <= jumper_code(jh_sync_r); // RULE_14
    end
  end

  // Setpoints pass unclipped; a value outside the span shows in the flags instead
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      temp_setp_r <= `CLSIB_SETP_TEMP_RST;
      hum_setp_r <= `CLSIB_SETP_HUM_RST;
    end else if (operating_mode_i) begin
      temp_setp_r <= hold_temp_i.setpoint; // RULE_07
      hum_setp_r <= hold_hum_i.setpoint; // RULE_08
    end else begin
      temp_setp_r <= trimmer_temp_setpoint_i; // RULE_07
      hum_setp_r <= trimmer_hum_setpoint_i; // RULE_08
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      temp_span_r <= '0;
    end else begin
      temp_span_r <= temp_span(temp_range_r, hold_temp_i.custom); // RULE_05
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hum_span_r <= '0;
    end else begin
      hum_span_r <= hum_span(hum_range_r, hold_hum_i.custom); // RULE_06
    end
  end

  // Analogue levels; overwrite only in bus mode
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      temp_level_r <= 16'h0000;
    end else if (operating_mode_i && output_overwrite_i) begin
      temp_level_r <= overwrite_temp_level_i; // RULE_15
    end else begin
      temp_level_r <= scale(meas_r.temp, temp_span_r); // RULE_02
    end
  end

  // Overwrite values pass unclipped, so the master owns their range
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hum_level_r <= 16'h0000;
    end else if (operating_mode_i && output_overwrite_i) begin
      hum_level_r <= overwrite_hum_level_i; // RULE_15
    end else begin
      hum_level_r <= scale($signed(meas_r.hum), hum_span_r); // RULE_02
    end
  end

  // Small setpoints give a negative release level, which the relay handles
  clsib_relay #(
    .WIDTH(WIDTH)
  ) u_temp_relay (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .value_i(meas_r.temp),
    .setpoint_i(temp_setp_r),
    .hyst_i(`CLSIB_TEMP_HYST),
    .range_lo_i(temp_span_r.lo),
    .range_hi_i(temp_span_r.hi),
    .relay_o(temp_relay),
    .out_of_range_o(temp_oor)
  );

  // Humidity is unsigned but never above 1000, so a signed compare is safe
  clsib_relay #(
    .WIDTH(WIDTH)
  ) u_hum_relay (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .value_i($signed(meas_r.hum)),
    .setpoint_i(hum_setp_r),
    .hyst_i(`CLSIB_HUM_HYST),
    .range_lo_i(hum_span_r.lo),
    .range_hi_i(hum_span_r.hi),
    .relay_o(hum_relay),
    .out_of_range_o(hum_oor)
  );

  // Register decode; reserved and unmapped words read zero
  always_comb begin
    look_data = 16'h0000; // RULE_16
    // Signed words go out as their raw two's complement bits
    case (look_addr)
      `CLSIB_ADDR_TEMP: look_data = meas_r.temp; // RULE_01
      `CLSIB_ADDR_HUM: look_data = meas_r.hum; // RULE_01
      `CLSIB_ADDR_DEW: look_data = meas_r.dew; // RULE_01
      `CLSIB_ADDR_TOUT: look_data = temp_level_r; // RULE_02
      `CLSIB_ADDR_HOUT: look_data = hum_level_r; // RULE_02
      `CLSIB_ADDR_TRELAY: look_data = {15'h0000, temp_relay}; // RULE_03
      `CLSIB_ADDR_HRELAY: look_data = {15'h0000, hum_relay}; // RULE_04
      `CLSIB_ADDR_TRANGE: look_data = {13'h0000, temp_range_r}; // RULE_05
      `CLSIB_ADDR_HRANGE: look_data = {13'h0000, hum_range_r}; // RULE_06
      `CLSIB_ADDR_TSETP: look_data = temp_setp_r; // RULE_07
      `CLSIB_ADDR_HSETP: look_data = hum_setp_r; // RULE_08
      `CLSIB_ADDR_THYST: look_data = `CLSIB_TEMP_HYST; // RULE_09
      `CLSIB_ADDR_HHYST: look_data = `CLSIB_HUM_HYST; // RULE_10
      `CLSIB_ADDR_TFLAG: look_data = {15'h0000, temp_oor}; // RULE_11
      `CLSIB_ADDR_HFLAG: look_data = {15'h0000, hum_oor}; // RULE_12
      `CLSIB_ADDR_LINK: look_data = {15'h0000, link_sync_r}; // RULE_13
      default: look_data = 16'h0000; // RULE_16
    endcase
  end

  // Two-cycle answer keeps the decode out of the request path
  clsib_read_port u_read_port (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .rd_req_i(rd_req_i),
    .rd_addr_i(rd_addr_i),
    .look_addr_o(look_addr),
    .look_data_i(look_data),
    .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o)
  );

  // Pins and registers share the same flops, so they never disagree
  assign temperature_analogue_out_o = temp_level_r;
  assign humidity_analogue_out_o = hum_level_r;
  assign first_relay_normally_open_o = temp_relay; // RULE_03
  assign second_relay_normally_open_o = hum_relay; // RULE_04

endmodule

// File: clsib_map.svh
/*
  Register addresses, field codes, fixed values and range limits of the
  climate sensor input register bank. Included by the bank, relay and read port modules.
*/
`ifndef CLSIB_MAP_SVH
`define CLSIB_MAP_SVH

// Input register addresses
`define CLSIB_ADDR_TEMP        8'h01
`define CLSIB_ADDR_HUM         8'h02
`define CLSIB_ADDR_DEW         8'h03
`define CLSIB_ADDR_RSVD_LO_FIRST 8'h04
`define CLSIB_ADDR_RSVD_LO_LAST  8'h0a
`define CLSIB_ADDR_TOUT        8'h0b
`define CLSIB_ADDR_HOUT        8'h0c
`define CLSIB_ADDR_TRELAY      8'h0d
`define CLSIB_ADDR_HRELAY      8'h0e
`define CLSIB_ADDR_TRANGE      8'h0f
`define CLSIB_ADDR_HRANGE      8'h10
`define CLSIB_ADDR_TSETP       8'h11
`define CLSIB_ADDR_HSETP       8'h12
`define CLSIB_ADDR_THYST       8'h13
`define CLSIB_ADDR_HHYST       8'h14
`define CLSIB_ADDR_TFLAG       8'h15
`define CLSIB_ADDR_HFLAG       8'h16
`define CLSIB_ADDR_RSVD_HI_FIRST 8'h17
`define CLSIB_ADDR_RSVD_HI_LAST  8'h1d
`define CLSIB_ADDR_LINK        8'h1e

// Fixed hysteresis, tenths
`define CLSIB_TEMP_HYST        16'h0014
`define CLSIB_HUM_HYST         16'h0032

// Range codes
`define CLSIB_RANGE_1          3'h1
`define CLSIB_RANGE_2          3'h2
`define CLSIB_RANGE_3          3'h3
`define CLSIB_RANGE_4          3'h4
`define CLSIB_RANGE_CUSTOM     3'h5

// Range limits, tenths
`define CLSIB_V_0              16'h0000
`define CLSIB_V_100            16'h0064
`define CLSIB_V_200            16'h00c8
`define CLSIB_V_300            16'h012c
`define CLSIB_V_400            16'h0190
`define CLSIB_V_500            16'h01f4
`define CLSIB_V_600            16'h0258
`define CLSIB_V_800            16'h0320
`define CLSIB_V_900            16'h0384
`define CLSIB_V_1000           16'h03e8

// Reset values of the active setpoints, and the full-scale output level
`define CLSIB_SETP_TEMP_RST    16'h00fa
`define CLSIB_SETP_HUM_RST     16'h01f4
`define CLSIB_OUT_FULL         16'h03e8

// Read pipeline latency in clock cycles
`define CLSIB_READ_LATENCY     2

`endif

// File: clsib_pkg.sv
/*
  Types shared by the climate sensor input register bank.
  Assumes clsib_map.svh is on the include path.
*/
package clsib_pkg;

  typedef struct packed {
    logic signed [15:0] temp;
    logic [15:0] hum;
    logic signed [15:0] dew;
  } clsib_meas_t;

  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] hi;
  } clsib_span_t;

  typedef struct packed {
    logic [2:0] range_code;
    logic signed [15:0] setpoint;
    clsib_span_t custom;
  } clsib_sel_t;

  typedef enum logic [1:0] {
    CLSIB_RD_IDLE = 2'b00,
    CLSIB_RD_LOOK = 2'b01,
    CLSIB_RD_DONE = 2'b11
  } clsib_rd_state_t;

endpackage

// File: clsib_relay.sv
/*
  One relay channel: setpoint switching with hysteresis and the
  setpoint-outside-range flag. Inputs come from the same clock domain.
*/
`timescale 1ns/10ps
`include "clsib_map.svh"

module clsib_relay #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Operating values
  input wire logic signed [WIDTH-1:0] value_i,
  input wire logic signed [WIDTH-1:0] setpoint_i,
  input wire logic signed [WIDTH-1:0] hyst_i,
  input wire logic [WIDTH-1:0] range_lo_i,
  input wire logic [WIDTH-1:0] range_hi_i,
  // Results
  output logic relay_o,
  output logic out_of_range_o
);

  logic relay_r;
  logic oor_r;
  logic signed [WIDTH:0] release_lvl;

  // One bit wider so a small setpoint minus hysteresis cannot wrap
  assign release_lvl = {setpoint_i[WIDTH-1], setpoint_i} - {hyst_i[WIDTH-1], hyst_i};

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      relay_r <= 1'b0;
    end else if (!relay_r && value_i >= setpoint_i) begin
      relay_r <= 1'b1; // RULE_18
    end else if (relay_r && $signed({value_i[WIDTH-1], value_i}) <= release_lvl) begin
      relay_r <= 1'b0; // RULE_18
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      oor_r <= 1'b0;
    end else begin
      oor_r <= setpoint_i < $signed({1'b0, range_lo_i[WIDTH-2:0]}) ||
               setpoint_i > $signed({1'b0, range_hi_i[WIDTH-2:0]});
    end
  end

  assign relay_o = relay_r;
  assign out_of_range_o = oor_r;

endmodule

// File: clsib_read_port.sv
/*
  Read port of the input register bank: takes an address, presents the
  word two cycles later. Reading has no side effects.
*/
`timescale 1ns/10ps
`include "clsib_map.svh"

module clsib_read_port (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Request
  input wire logic rd_req_i,
  input wire logic [7:0] rd_addr_i,
  // Word supplied by the bank for the held address
  output logic [7:0] look_addr_o,
  input wire logic [15:0] look_data_i,
  // Answer
  output logic rd_valid_o,
  output logic [15:0] rd_data_o
);

  clsib_pkg::clsib_rd_state_t state_r;
  clsib_pkg::clsib_rd_state_t state_nxt;
  logic [7:0] addr_r;
  logic [15:0] data_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      clsib_pkg::CLSIB_RD_IDLE: begin
        if (rd_req_i) begin
          state_nxt = clsib_pkg::CLSIB_RD_LOOK;
        end
      end
      clsib_pkg::CLSIB_RD_LOOK: state_nxt = clsib_pkg::CLSIB_RD_DONE;
      clsib_pkg::CLSIB_RD_DONE: state_nxt = clsib_pkg::CLSIB_RD_IDLE;
      default: state_nxt = clsib_pkg::CLSIB_RD_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_r <= clsib_pkg::CLSIB_RD_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      addr_r <= 8'h00;
    end else if (state_r == clsib_pkg::CLSIB_RD_IDLE && rd_req_i) begin
      addr_r <= rd_addr_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      data_r <= 16'h0000;
    end else if (state_r == clsib_pkg::CLSIB_RD_LOOK) begin
      data_r <= look_data_i; // RULE_17
    end
  end

  assign look_addr_o = addr_r;
  assign rd_valid_o = (state_r == clsib_pkg::CLSIB_RD_DONE);
  assign rd_data_o = data_r;

endmodule

// File: clsib_master_model.sv
/*
  Behavioural reader of the input registers, standing in for the bus master.
  Waits up to eight edges after dropping the request for the bank's answer.
*/
`timescale 1ns/10ps
module clsib_master_model (
  // Clock
  input wire logic clock_i,
  // Answer from the bank
  input wire logic rd_valid_i,
  input wire logic [15:0] rd_data_i,
  // Request to the bank
  output logic rd_req_o,
  output logic [7:0] rd_addr_o
);
  initial begin
    rd_req_o = 1'b0;
    rd_addr_o = 8'h00;
  end

  // One word per request; the address stays put until the answer is taken
  task automatic read(input logic [7:0] addr, output logic [15:0] data);
    int n;
    n = 0;
    data = 16'hxxxx;
    @(posedge clock_i);
    #5;
    rd_req_o = 1'b1;
    rd_addr_o = addr;
    @(posedge clock_i);
    #5;
    rd_req_o = 1'b0;
    while (rd_valid_i !== 1'b1 && n < 8) begin
      @(posedge clock_i);
      #5;
      n++;
    end
    if (rd_valid_i === 1'b1) begin
      data = rd_data_i;
    end
  endtask
endmodule

// File: clsib_bank_assertions.sv
/*
  Checker for the input register bank: read timing, fixed and reserved
  words, temperature overwrite level and relay. Sees top-level ports only.
*/
`timescale 1ns/10ps
module clsib_bank_assertions (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Inputs watched
  input wire clsib_pkg::clsib_meas_t meas_i,
  input wire logic [15:0] trimmer_temp_setpoint_i,
  input wire logic operating_mode_i,
  input wire logic output_overwrite_i,
  input wire logic [15:0] overwrite_temp_level_i,
  input wire logic rd_req_i,
  input wire logic [7:0] rd_addr_i,
  // Outputs watched
  input wire logic rd_valid_o,
  input wire logic [15:0] rd_data_o,
  input wire logic [15:0] temperature_analogue_out_o,
  input wire logic first_relay_normally_open_o
);
  logic [1:0] phase_r;
  logic take;

  assign take = rd_req_i && (phase_r == 2'h0);

  // Mirrors the port: requests during a pending answer are dropped
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      phase_r <= 2'h0;
    end else if (take || phase_r != 2'h0) begin
      phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  a_read_latency: assert property (take |=> !rd_valid_o ##1 rd_valid_o)
    else $error("read answer not two cycles after request");
  a_valid_single: assert property (rd_valid_o |=> !rd_valid_o)
    else $error("read valid longer than one cycle");
  a_valid_cause: assert property (rd_valid_o |-> phase_r == 2'h2)
    else $error("read valid without request");
  a_reserved_zero: assert property (take && (rd_addr_i inside {[8'h04:8'h0a], [8'h17:8'h1d]})
    |-> ##2 rd_data_o == 16'h0000) else $error("reserved word not zero");
  a_temp_hyst: assert property (take && rd_addr_i == 8'h13 |-> ##2 rd_data_o == 16'h0014)
    else $error("temperature hysteresis word wrong");
  a_hum_hyst: assert property (take && rd_addr_i == 8'h14 |-> ##2 rd_data_o == 16'h0032)
    else $error("humidity hysteresis word wrong");
  a_temp_reading: assert property (take && rd_addr_i == 8'h01 && $stable(meas_i.temp)
    |-> ##2 rd_data_o == $past(meas_i.temp, 2)) else $error("temperature word wrong");
  a_overwrite_level: assert property ((operating_mode_i && output_overwrite_i
    && $stable(overwrite_temp_level_i))[*4] |-> temperature_analogue_out_o == overwrite_temp_level_i)
    else $error("overwrite level not applied");
  a_relay_on: assert property ((!operating_mode_i
    && $signed(meas_i.temp) >= $signed(trimmer_temp_setpoint_i))[*4] |-> first_relay_normally_open_o)
    else $error("temperature relay not on at setpoint");
  a_relay_off: assert property ((!operating_mode_i
    && $signed(meas_i.temp) <= $signed(trimmer_temp_setpoint_i) - 20)[*4] |-> !first_relay_normally_open_o)
    else $error("temperature relay not off below hysteresis");

  c_read: cover property (take ##2 rd_valid_o);
  c_relay: cover property ($rose(first_relay_normally_open_o));
  c_overwrite: cover property (operating_mode_i && output_overwrite_i);
endmodule

bind clsib_bank clsib_bank_assertions u_chk (
  .clock_i, .rst_i, .meas_i, .trimmer_temp_setpoint_i, .operating_mode_i, .output_overwrite_i,
  .overwrite_temp_level_i, .rd_req_i, .rd_addr_i, .rd_valid_o, .rd_data_o,
  .temperature_analogue_out_o, .first_relay_normally_open_o
);

// File: climate_sensor_input_register_bank_tb.sv
/*
  Self-checking bench for the climate sensor input register bank.
  Reads go through the master model; settle waits cover the pin synchronisers.
*/
`timescale 1ns/10ps
module climate_sensor_input_register_bank_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  clsib_pkg::clsib_meas_t meas;
  clsib_pkg::clsib_sel_t ht, hh;
  logic lost, mode, ovw, rd_req, rd_valid, t_rel, h_rel;
  logic [2:0] jt, jh;
  logic [15:0] tt, th, ot, oh, rd_data, t_out, h_out;
  logic [7:0] rd_addr;
  int bad_count = 0;
  int compares = 0;

  always #25 clk = ~clk;

  clsib_bank dut (.clock_i(clk), .rst_i(rst), .meas_i(meas), .sensor_link_lost_i(lost),
    .jumper_temp_range_i(jt), .jumper_hum_range_i(jh), .trimmer_temp_setpoint_i(tt),
    .trimmer_hum_setpoint_i(th), .operating_mode_i(mode), .output_overwrite_i(ovw),
    .hold_temp_i(ht), .hold_hum_i(hh), .overwrite_temp_level_i(ot), .overwrite_hum_level_i(oh),
    .rd_req_i(rd_req), .rd_addr_i(rd_addr), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
    .temperature_analogue_out_o(t_out), .humidity_analogue_out_o(h_out),
    .first_relay_normally_open_o(t_rel), .second_relay_normally_open_o(h_rel));

  clsib_master_model mdl (.clock_i(clk), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
    .rd_req_o(rd_req), .rd_addr_o(rd_addr));

  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    mdl.read(a, d);
    check($sformatf("word %h", a), d, e);
  endtask

  // Long enough for the jumper synchroniser plus the selection and output stages
  task automatic settle();
    repeat (6) @(posedge clk);
    #5;
  endtask

  task automatic t_meas();
    meas = {16'hffc9, 16'h03e8, 16'h00c8};
    settle();
    rd(8'h01, 16'hffc9);
    rd(8'h02, 16'h03e8);
    rd(8'h03, 16'h00c8);
  endtask

  task automatic t_fixed();
    for (int a = 4; a <= 10; a++) rd(8'(a), 16'h0000);
    for (int a = 23; a <= 29; a++) rd(8'(a), 16'h0000);
    rd(8'h13, 16'h0014);
    rd(8'h14, 16'h0032);
  endtask

  task automatic t_select();
    for (int c = 1; c <= 4; c++) begin
      jt = 3'(c);
      jh = 3'(5 - c);
      settle();
      rd(8'h0f, 16'(c));
      rd(8'h10, 16'(5 - c));
    end
    rd(8'h11, 16'h0064);
    rd(8'h12, 16'h01f4);
    mode = 1'b1;
    for (int c = 1; c <= 5; c++) begin
      ht.range_code = 3'(c);
      hh.range_code = 3'(c);
      settle();
      rd(8'h0f, 16'(c));
      rd(8'h10, 16'(c));
    end
    ht.setpoint = 16'h007b;
    hh.setpoint = 16'h0384;
    settle();
    rd(8'h11, 16'h007b);
    rd(8'h12, 16'h0384);
  endtask

  task automatic t_flags();
    ht = {3'h1, 16'h0190, 16'h0000, 16'h01f4};
    hh = {3'h2, 16'h0384, 16'h0000, 16'h03e8};
    settle();
    rd(8'h15, 16'h0001);
    rd(8'h16, 16'h0001);
    ht.setpoint = 16'h012c;
    hh.setpoint = 16'h0258;
    settle();
    rd(8'h15, 16'h0000);
    rd(8'h16, 16'h0000);
  endtask

  task automatic t_relay();
    ht = {3'h4, 16'h00fa, 16'h0000, 16'h01f4};
    hh = {3'h4, 16'h01f4, 16'h0000, 16'h03e8};
    meas = {16'h00fa, 16'h01f4, 16'h0000};
    settle();
    rd(8'h0d, 16'h0001);
    rd(8'h0e, 16'h0001);
    check("second relay pin", {15'h0000, h_rel}, 16'h0001);
    meas = {16'h00e7, 16'h01c3, 16'h0000};
    settle();
    check("first relay pin", {15'h0000, t_rel}, 16'h0001);
    rd(8'h0e, 16'h0001);
    meas = {16'h00e6, 16'h01c2, 16'h0000};
    settle();
    rd(8'h0d, 16'h0000);
    rd(8'h0e, 16'h0000);
    // A reading below zero must still release the relay
    meas = {16'h00fa, 16'h01f4, 16'h0000};
    settle();
    check("first relay pin", {15'h0000, t_rel}, 16'h0001);
    meas = {16'hfff6, 16'h01f4, 16'h0000};
    settle();
    check("first relay pin", {15'h0000, t_rel}, 16'h0000);
  endtask

  task automatic t_levels();
    meas = {16'h00fa, 16'h00fa, 16'h0000};
    settle();
    rd(8'h0b, 16'h01f4);
    rd(8'h0c, 16'h00fa);
    check("temperature level pin", t_out, 16'h01f4);
    ot = 16'h0309;
    oh = 16'h0011;
    ovw = 1'b1;
    settle();
    rd(8'h0b, 16'h0309);
    rd(8'h0c, 16'h0011);
    check("humidity level pin", h_out, 16'h0011);
    mode = 1'b0;
    settle();
    rd(8'h0b, 16'h01f4);
    rd(8'h0d, 16'h0001);
    rd(8'h11, 16'h0064);
  endtask

  task automatic t_link();
    lost = 1'b1;
    settle();
    rd(8'h1e, 16'h0001);
    lost = 1'b0;
    settle();
    rd(8'h1e, 16'h0000);
  endtask

  task automatic test_done();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    meas = {16'h0000, 16'h0000, 16'h0000};
    ht = {3'h1, 16'h00fa, 16'h0000, 16'h01f4};
    hh = {3'h1, 16'h01f4, 16'h0000, 16'h03e8};
    lost = 1'b0;
    mode = 1'b0;
    ovw = 1'b0;
    jt = 3'h1;
    jh = 3'h1;
    tt = 16'h0064;
    th = 16'h01f4;
    ot = 16'h0000;
    oh = 16'h0000;
    repeat (8) @(posedge clk);
    #5;
    rst = 1'b0;
    t_meas();
    t_fixed();
    t_select();
    t_flags();
    t_relay();
    t_levels();
    t_link();
    test_done();
  end

  // Many times the cycles the scenarios need
  initial begin
    #500000;
    bad_count++;
    test_done();
  end
endmodule
